// ---- rtl/lcdid_map.svh ----
`ifndef LCDID_MAP_SVH
`define LCDID_MAP_SVH
// Overview of operation
// - power-on init holds busy about 10 ms
// - init order: clear, function, display, entry
// - init selects 8-bit, one line, 5x8
// - init sets increment, no shift on entry
// - host reaches only command and data holders
// - while busy only status read is served
// - command 01 clears display, pointer to zero
// - return home zeroes pointer and display shift
// - entry mode stores step direction, shift flag
// - display control stores display, cursor, blink
// - shift command moves cursor or display
// - function set stores width, lines, font
// - glyph address set targets glyph memory
// - display address set targets display memory
// - status read returns busy and pointer
// - data write steps pointer by one
// - shift on entry moves display with write
// - nibble mode: high half then low half
////////////////////////////////////////////////////////////
// timing
`define LCDID_CLK_KHZ 25000
`define LCDID_T_CMD_NS 37000
`define LCDID_T_HOME_NS 1520000
`define LCDID_T_INIT_NS 10000000
// longest times, so the division rounds down
`define LCDID_CYCLES(ns) ((64'(ns) * 64'(`LCDID_CLK_KHZ)) / 64'd1000000)
////////////////////////////////////////////////////////////
// command fields
`define LCDID_B_ID 1
`define LCDID_B_SH 0
`define LCDID_B_DISP 2
`define LCDID_B_CUR 1
`define LCDID_B_BLINK 0
`define LCDID_B_SC 3
`define LCDID_B_RL 2
`define LCDID_B_WIDTH 4
`define LCDID_B_LINES 3
`define LCDID_B_FONT 2
////////////////////////////////////////////////////////////
// values
`define LCDID_BLANK 8'h20
`define LCDID_CLR_LAST 7'h7F
`define LCDID_GLYPH_BASE 2'h2
`define LCDID_INIT_FN 3'h4
`define LCDID_INIT_CTL 3'h0
`define LCDID_INIT_ENTRY 2'h2
`endif

// ---- rtl/lcdid_pkg.sv ----
package lcdid_pkg;
  typedef enum logic [3:0] {
    LCDID_CLEAR = 4'h1,
    LCDID_INIT = 4'h2,
    LCDID_IDLE = 4'h4,
    LCDID_EXEC = 4'h8
  } lcdid_fsm_t;

  typedef struct packed {
    lcdid_fsm_t st;
    logic init;
    logic [1:0] step;
    logic [17:0] cnt;
    logic [6:0] clr;
    logic [6:0] ptr;
    logic glyph;
    logic inc;
    logic shift_en;
    logic disp_on;
    logic cur_on;
    logic blink_on;
    logic bus8;
    logic lines2;
    logic font10;
    logic [6:0] shift;
    logic nib;
    logic [3:0] hi;
    logic rd_mem;
    logic rd_lo;
    logic [7:0] stat;
  } lcdid_regs_t;
endpackage : lcdid_pkg

// ---- rtl/lcdid_mem.sv ----
module lcdid_mem (
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic re,
  input wire logic [7:0] addr,
  input wire logic [7:0] wd,
  output logic [7:0] rd
);
  // array kept outside a struct: it maps onto a plain ram
  logic [7:0] mem [0:255];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wd;
    end
  end

  // read data only move on a read, so a nibble pair sees one byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd <= 8'h00;
    end else if (re) begin
      rd <= mem[addr];
    end
  end
endmodule : lcdid_mem

// ---- rtl/lcdid_decoder.sv ----
`include "lcdid_map.svh"

module lcdid_decoder #(
  parameter int HOME_CYCLES = int'(`LCDID_CYCLES(`LCDID_T_HOME_NS)),
  parameter int INIT_CYCLES = int'(`LCDID_CYCLES(`LCDID_T_INIT_NS))
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_select,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic busy_indicator,
  output logic [6:0] addr_pointer,
  output logic glyph_sel,
  output logic bus_width_sel,
  output logic two_lines,
  output logic font_tall,
  output logic disp_on,
  output logic cursor_on,
  output logic blink_on,
  output logic [6:0] disp_shift
);
  import lcdid_pkg::*;

  localparam logic [17:0] CMD_RUN = 18'(`LCDID_CYCLES(`LCDID_T_CMD_NS));
  localparam logic [17:0] HOME_RUN = 18'(HOME_CYCLES);
  localparam logic [17:0] INIT_RUN = 18'(INIT_CYCLES);
  localparam lcdid_regs_t RST = '{
    st: LCDID_CLEAR,
    init: 1'h1,
    cnt: INIT_RUN - 18'h1,
    default: '0
  };

  lcdid_regs_t q;
  lcdid_regs_t d;
  logic busy;
  logic wr_go;
  logic wr_cmd;
  logic rd_go;
  logic half_ok;
  logic mem_we;
  logic mem_re;
  logic [7:0] mem_addr;
  logic [7:0] mem_wd;
  logic [7:0] mem_q;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic [17:0] run;

  function automatic logic [6:0] lcdid_step(
    input logic [6:0] p,
    input logic up,
    input logic g
  );
    logic [6:0] n;
    n = up ? p + 7'h01 : p - 7'h01;
    return g ? {1'h0, n[5:0]} : n;
  endfunction : lcdid_step

  ////////////////////////////////////////////////////////////
  // host access qualification
  assign busy = (q.st != LCDID_IDLE);
  assign byte_in = q.bus8 ? wdata : {q.hi, wdata[7:4]};
  // a write is dropped whole while busy, nibble state untouched
  assign wr_go = wr_stb && !busy && (q.bus8 || q.nib);
  assign wr_cmd = wr_go && !reg_select;
  // data reads run only when idle; the status read always answers
  assign rd_go = rd_stb && reg_select && !busy && (q.bus8 || !q.nib);
  assign half_ok = (wr_stb && !busy) || (rd_stb && (!busy || !reg_select || q.nib));

  ////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    run = 18'h0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_wd = byte_in;
    mem_addr = q.glyph ? {`LCDID_GLYPH_BASE, q.ptr[5:0]} : {1'h0, q.ptr};
    if (!q.bus8 && half_ok) begin
      d.nib = ~q.nib;
    end
    if (wr_stb && !q.bus8 && !q.nib && !busy) begin
      d.hi = wdata[7:4];
    end
    if (rd_stb) begin
      d.rd_lo = !q.bus8 && q.nib;
      if (rd_go) begin
        d.rd_mem = 1'b1;
        mem_re = 1'b1;
        d.ptr = lcdid_step(q.ptr, q.inc, q.glyph);
        run = CMD_RUN;
      end else if (q.bus8 || !q.nib) begin
        d.rd_mem = 1'b0;
        d.stat = {busy, q.ptr};
      end
    end
    if (wr_go && reg_select) begin
      mem_we = 1'b1;
      d.ptr = lcdid_step(q.ptr, q.inc, q.glyph);
      if (q.shift_en && !q.glyph) begin
        d.shift = q.inc ? q.shift + 7'h01 : q.shift - 7'h01;
      end
      run = CMD_RUN;
    end else if (wr_cmd) begin
      casez (byte_in)
        8'b1???????: begin
          d.ptr = byte_in[6:0];
          d.glyph = 1'b0;
          run = CMD_RUN;
        end
        8'b01??????: begin
          d.ptr = {1'h0, byte_in[5:0]};
          d.glyph = 1'b1;
          run = CMD_RUN;
        end
        8'b001?????: begin
          d.bus8 = byte_in[`LCDID_B_WIDTH];
          d.lines2 = byte_in[`LCDID_B_LINES];
          d.font10 = byte_in[`LCDID_B_FONT];
          d.nib = 1'b0;
          run = CMD_RUN;
        end
        8'b0001????: begin
          if (byte_in[`LCDID_B_SC]) begin
            // right shift moves the window, so the offset drops
            d.shift = byte_in[`LCDID_B_RL] ? q.shift - 7'h01 : q.shift + 7'h01;
          end else begin
            d.ptr = lcdid_step(q.ptr, byte_in[`LCDID_B_RL], q.glyph);
          end
          run = CMD_RUN;
        end
        8'b00001???: begin
          d.disp_on = byte_in[`LCDID_B_DISP];
          d.cur_on = byte_in[`LCDID_B_CUR];
          d.blink_on = byte_in[`LCDID_B_BLINK];
          run = CMD_RUN;
        end
        8'b000001??: begin
          d.inc = byte_in[`LCDID_B_ID];
          d.shift_en = byte_in[`LCDID_B_SH];
          run = CMD_RUN;
        end
        8'b0000001?: begin
          d.ptr = 7'h00;
          d.shift = 7'h00;
          d.glyph = 1'b0;
          run = HOME_RUN;
        end
        8'b00000001: begin
          d.st = LCDID_CLEAR;
          d.clr = 7'h00;
          d.init = 1'b0;
          d.cnt = HOME_RUN - 18'h1;
        end
        default: begin
          d.ptr = q.ptr;
        end
      endcase
    end
    case (q.st)
      LCDID_CLEAR: begin
        // one cell a cycle; the busy count runs on meanwhile
        mem_we = 1'b1;
        mem_addr = {1'h0, q.clr};
        mem_wd = `LCDID_BLANK;
        d.clr = q.clr + 7'h01;
        if (q.cnt != 18'h0) begin
          d.cnt = q.cnt - 18'h1;
        end
        if (q.clr == `LCDID_CLR_LAST) begin
          d.ptr = 7'h00;
          d.shift = 7'h00;
          d.glyph = 1'b0;
          d.step = 2'h0;
          d.st = q.init ? LCDID_INIT : LCDID_EXEC;
        end
      end
      LCDID_INIT: begin
        d.step = q.step + 2'h1;
        if (q.cnt != 18'h0) begin
          d.cnt = q.cnt - 18'h1;
        end
        case (q.step)
          2'h0: begin
            {d.bus8, d.lines2, d.font10} = `LCDID_INIT_FN;
            d.nib = 1'b0;
          end
          2'h1: begin
            {d.disp_on, d.cur_on, d.blink_on} = `LCDID_INIT_CTL;
          end
          default: begin
            {d.inc, d.shift_en} = `LCDID_INIT_ENTRY;
            d.st = LCDID_EXEC;
          end
        endcase
      end
      LCDID_EXEC: begin
        if (q.cnt == 18'h0) begin
          d.st = LCDID_IDLE;
          d.init = 1'b0;
        end else begin
          d.cnt = q.cnt - 18'h1;
        end
      end
      LCDID_IDLE: begin
        d.init = 1'b0;
      end
      default: begin
        d.st = LCDID_IDLE;
      end
    endcase
    if (run != 18'h0) begin
      d.st = LCDID_EXEC;
      d.cnt = run - 18'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////
  // memory and outputs
  lcdid_mem u_mem (
    .mclk(mclk),
    .rst(rst),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wd(mem_wd),
    .rd(mem_q)
  );

  assign rd_byte = q.rd_mem ? mem_q : q.stat;
  // narrow bus answers on the upper lines only
  assign rdata = q.bus8 ? rd_byte : {q.rd_lo ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
  assign busy_indicator = busy;
  assign addr_pointer = q.ptr;
  assign glyph_sel = q.glyph;
  assign bus_width_sel = q.bus8;
  assign two_lines = q.lines2;
  assign font_tall = q.font10;
  assign disp_on = q.disp_on;
  assign cursor_on = q.cur_on;
  assign blink_on = q.blink_on;
  assign disp_shift = q.shift;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_busy_fall;
    $fell(busy_indicator) |-> $past(q.cnt) == 18'h0 && $past(q.st) == LCDID_EXEC;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy ended early");

  property p_init_order;
    (q.st == LCDID_CLEAR && q.init && q.clr == 7'h7F)
      |=> q.st == LCDID_INIT ##3 q.st == LCDID_EXEC;
  endproperty
  a_init_order: assert property (p_init_order) else $error("init order");

  property p_init_fn;
    (q.st == LCDID_INIT && q.step == 2'h0) |=> q.bus8 && !q.lines2 && !q.font10;
  endproperty
  a_init_fn: assert property (p_init_fn) else $error("init function set");

  property p_init_ctl;
    (q.st == LCDID_INIT && q.step == 2'h1) |=> !q.disp_on && !q.cur_on && !q.blink_on;
  endproperty
  a_init_ctl: assert property (p_init_ctl) else $error("init display off");

  property p_init_entry;
    (q.st == LCDID_INIT && q.step == 2'h2) |=> q.inc && !q.shift_en && busy_indicator;
  endproperty
  a_init_entry: assert property (p_init_entry) else $error("init entry mode");

  property p_data_keeps_cfg;
    (wr_go && reg_select) |=> $stable({q.disp_on, q.cur_on, q.blink_on, q.bus8, q.inc});
  endproperty
  a_data_keeps_cfg: assert property (p_data_keeps_cfg) else $error("data hit config");

  property p_refuse;
    (wr_stb && q.st == LCDID_EXEC) |=> $stable(q.ptr) && $stable(q.glyph) && $stable(q.disp_on);
  endproperty
  a_refuse: assert property (p_refuse) else $error("busy write acted");

  property p_clear;
    (wr_cmd && byte_in == 8'h01)
      |=> q.st == LCDID_CLEAR ##128 (q.st == LCDID_EXEC && q.ptr == 7'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("clear sequence");

  property p_home;
    (wr_cmd && byte_in[7:1] == 7'h01) |=> q.ptr == 7'h00 && q.shift == 7'h00 && busy_indicator;
  endproperty
  a_home: assert property (p_home) else $error("return home");

  property p_entry;
    (wr_cmd && byte_in[7:2] == 6'h01)
      |=> q.inc == $past(byte_in[1]) && q.shift_en == $past(byte_in[0]);
  endproperty
  a_entry: assert property (p_entry) else $error("entry mode");

  property p_dispctl;
    (wr_cmd && byte_in[7:3] == 5'h01)
      |=> {q.disp_on, q.cur_on, q.blink_on} == $past(byte_in[2:0]);
  endproperty
  a_dispctl: assert property (p_dispctl) else $error("display control");

  property p_shift;
    (wr_cmd && byte_in[7:4] == 4'h1 && byte_in[3])
      |=> q.ptr == $past(q.ptr) && q.shift != $past(q.shift);
  endproperty
  a_shift: assert property (p_shift) else $error("display shift");

  property p_fnset;
    (wr_cmd && byte_in[7:5] == 3'h1)
      |=> {q.bus8, q.lines2, q.font10} == $past(byte_in[4:2]);
  endproperty
  a_fnset: assert property (p_fnset) else $error("function set");

  property p_glyph_addr;
    (wr_cmd && byte_in[7:6] == 2'h1) |=> q.glyph && q.ptr == {1'h0, $past(byte_in[5:0])};
  endproperty
  a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address");

  property p_disp_addr;
    (wr_cmd && byte_in[7]) |=> !q.glyph && q.ptr == $past(byte_in[6:0]);
  endproperty
  a_disp_addr: assert property (p_disp_addr) else $error("display address");

  property p_status;
    (rd_stb && !reg_select && q.bus8) |=> rdata == {$past(busy_indicator), $past(q.ptr)};
  endproperty
  a_status: assert property (p_status) else $error("status read");

  property p_autoinc;
    (wr_go && reg_select && q.inc && !q.glyph) |=> q.ptr == $past(q.ptr) + 7'h01;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("pointer step");

  property p_shift_entry;
    (wr_go && reg_select && q.shift_en && !q.glyph) |=> q.shift != $past(q.shift);
  endproperty
  a_shift_entry: assert property (p_shift_entry) else $error("entry shift");

  property p_nibble;
    (wr_stb && !q.bus8 && !q.nib && !busy) |=> q.nib && !busy_indicator;
  endproperty
  a_nibble: assert property (p_nibble) else $error("first nibble acted");

  property p_data_sel;
    (wr_go && reg_select) |-> mem_we && mem_addr[7] == q.glyph;
  endproperty
  a_data_sel: assert property (p_data_sel) else $error("wrong memory");

  c_init_done: cover property ($fell(busy_indicator) && q.bus8);
  c_nib_write: cover property (wr_go && !q.bus8 && reg_select);
  c_data_read: cover property (rd_go ##1 busy_indicator [*1] ##0 q.rd_mem);
  c_refused: cover property (wr_stb && busy_indicator);
endmodule : lcdid_decoder

// ---- bench/lcdid_host.sv ----
module lcdid_host (
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output logic reg_select,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic four_bit;
  initial begin
    four_bit = 1'b0;
    reg_select = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // one strobe; released bus shows the inverse so stale data cannot pass
  task xfer(input logic rs, input logic is_wr, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    reg_select <= rs;
    wr_stb <= is_wr;
    rd_stb <= !is_wr;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    wdata <= ~d;
    if (!is_wr) begin
      @(posedge mclk);
    end
    q = rdata;
  endtask : xfer
  task wr(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    if (four_bit) begin
      xfer(rs, 1'b1, {d[7:4], 4'h5}, q);
      xfer(rs, 1'b1, {d[3:0], 4'hA}, q);
    end else begin
      xfer(rs, 1'b1, d, q);
    end
  endtask : wr
  task rd(input logic rs, output logic [7:0] d);
    logic [7:0] a;
    logic [7:0] b;
    if (four_bit) begin
      xfer(rs, 1'b0, 8'h00, a);
      xfer(rs, 1'b0, 8'h00, b);
      d = {a[7:4], b[7:4]};
    end else begin
      xfer(rs, 1'b0, 8'h00, d);
    end
  endtask : rd
  // bounded so a stuck flag ends here, not in the bench timeout
  task poll(output logic [7:0] st);
    int n;
    n = 0;
    rd(1'b0, st);
    while (st[7] !== 1'b0 && n < 3000) begin
      rd(1'b0, st);
      n++;
    end
  endtask : poll
endmodule : lcdid_host

// ---- bench/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import lcdid_pkg::*;
  localparam int HOME = 200;
  localparam int INIT = 200;
  logic mclk, rst, reg_select, wr_stb, rd_stb, busy_indicator, glyph_sel, bus_width_sel;
  logic two_lines, font_tall, disp_on, cursor_on, blink_on;
  logic [7:0] wdata, rdata, st, d;
  logic [6:0] addr_pointer, disp_shift;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int n, r;
  lcdid_decoder #(.HOME_CYCLES(HOME), .INIT_CYCLES(INIT)) u_lcdid_decoder (
    .mclk(mclk), .rst(rst), .reg_select(reg_select), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wdata(wdata), .rdata(rdata), .busy_indicator(busy_indicator),
    .addr_pointer(addr_pointer), .glyph_sel(glyph_sel), .bus_width_sel(bus_width_sel),
    .two_lines(two_lines), .font_tall(font_tall), .disp_on(disp_on), .cursor_on(cursor_on),
    .blink_on(blink_on), .disp_shift(disp_shift));
  lcdid_host u_lcdid_host (.mclk(mclk), .rdata(rdata), .reg_select(reg_select),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task close_out;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // whole run is about 31k cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end
  task cmd(input logic rs, input logic [7:0] c);
    u_lcdid_host.wr(rs, c);
    u_lcdid_host.poll(st);
  endtask : cmd
  task rdm(input logic [7:0] a, output logic [7:0] q);
    cmd(1'b0, a);
    u_lcdid_host.rd(1'b1, q);
    u_lcdid_host.poll(st);
  endtask : rdm
  // sampled mid-cycle so the count cannot race the edge that drops busy
  task busy_len(output int k);
    k = 0;
    @(negedge mclk);
    while (busy_indicator === 1'b1 && k < 5000) begin
      k++;
      @(negedge mclk);
    end
  endtask : busy_len
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    r = cycles;
    @(posedge mclk);
    chk(8'(busy_indicator), 8'h01);
    u_lcdid_host.rd(1'b0, st);
    chk(8'(st[7]), 8'h01);
    repeat (INIT - 24) @(posedge mclk);
    chk(8'(busy_indicator), 8'h01);
    u_lcdid_host.poll(st);
    chk(st, 8'h00);
    chk(8'(cycles - r < INIT + 12), 8'h01);
    chk(8'({bus_width_sel, two_lines, font_tall}), 8'h04);
    chk(8'({disp_on, cursor_on, blink_on}), 8'h00);
    u_lcdid_host.wr(1'b1, 8'h31);
    busy_len(n);
    chk(8'(n == 925), 8'h01);
    chk(8'({addr_pointer, disp_shift}), 8'h80);
    rdm(8'h81, d);
    chk(d, 8'h20);
    rdm(8'h80, d);
    chk(d, 8'h31);
    $display("test init done");
    u_lcdid_host.wr(1'b0, 8'h0E);
    busy_len(n);
    chk(8'(n == 925), 8'h01);
    chk(8'({disp_on, cursor_on, blink_on}), 8'h06);
    u_lcdid_host.wr(1'b0, 8'h0F);
    u_lcdid_host.wr(1'b0, 8'h08);
    u_lcdid_host.rd(1'b1, d);
    chk(d, 8'h81);
    u_lcdid_host.poll(st);
    chk(8'({disp_on, cursor_on, blink_on}), 8'h07);
    $display("test control done");
    cmd(1'b0, 8'h90);
    cmd(1'b0, 8'h04);
    cmd(1'b1, 8'h44);
    chk(8'(addr_pointer), 8'h0F);
    cmd(1'b0, 8'h07);
    cmd(1'b1, 8'h45);
    chk(8'({addr_pointer, disp_shift}), 8'h10 << 7 | 8'h01);
    cmd(1'b0, 8'h18);
    chk(8'(disp_shift), 8'h02);
    cmd(1'b0, 8'h1C);
    chk(8'(disp_shift), 8'h01);
    cmd(1'b0, 8'h10);
    chk(8'(addr_pointer), 8'h0F);
    cmd(1'b0, 8'h14);
    chk(8'({addr_pointer, disp_shift}), 8'h10 << 7 | 8'h01);
    $display("test entry done");
    cmd(1'b0, 8'h03);
    chk(8'({addr_pointer, disp_shift}), 8'h00);
    rdm(8'h8F, d);
    chk(d, 8'h45);
    chk(8'(addr_pointer), 8'h10);
    cmd(1'b0, 8'h4A);
    chk(8'({glyph_sel, addr_pointer}), 8'h8A);
    cmd(1'b1, 8'h1F);
    rdm(8'h4A, d);
    chk(d, 8'h1F);
    rdm(8'h8A, d);
    chk(d, 8'h20);
    chk(8'(glyph_sel), 8'h00);
    $display("test memory done");
    cmd(1'b0, 8'h18);
    cmd(1'b0, 8'h01);
    chk(8'({glyph_sel, addr_pointer}), 8'h00);
    chk(8'(disp_shift), 8'h00);
    rdm(8'h8F, d);
    chk(d, 8'h20);
    $display("test clear done");
    u_lcdid_host.wr(1'b0, 8'h2C);
    // narrow bus up to the 8'h30 function set, so even the busy poll comes in halves
    u_lcdid_host.four_bit = 1'b1;
    u_lcdid_host.poll(st);
    chk(8'({bus_width_sel, two_lines, font_tall}), 8'h03);
    cmd(1'b0, 8'h85);
    chk(st, 8'h05);
    cmd(1'b1, 8'h96);
    rdm(8'h85, d);
    chk(d, 8'h96);
    u_lcdid_host.wr(1'b0, 8'h30);
    u_lcdid_host.four_bit = 1'b0;
    u_lcdid_host.poll(st);
    chk(8'(bus_width_sel), 8'h01);
    $display("test nibble done");
    close_out();
  end
endmodule : testbench
